// file: rtl/power_stage_pkg.sv
/*
  Shared constants, types and the command decoder of the power stage
  control block. Assumes a 200 MHz core clock that also serves as the
  internal oscillator for every timeout.
*/
`default_nettype none

package power_stage_pkg;

  // ---------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_FREQ_MHZ = 200;
  localparam int unsigned CLEAR_TIMEOUT_US = 100;
  localparam int unsigned CLEAR_TIMEOUT_CYC = CLEAR_TIMEOUT_US * CLK_FREQ_MHZ;
  localparam int unsigned LIMIT_OFF_US = 100;
  localparam int unsigned LIMIT_OFF_CYC = LIMIT_OFF_US * CLK_FREQ_MHZ;
  localparam int unsigned TIMER_W = 15;
  localparam int unsigned NUM_OUT = 5;

  // ---------------------------------------------------------------------
  // register map (byte addresses) and fields
  // ---------------------------------------------------------------------
  localparam logic [11:0] STATUS_OFF = 12'h000;
  localparam logic [11:0] CTRL_OFF = 12'h004;
  localparam logic [11:0] DRIVE_OFF = 12'h008;
  localparam int unsigned ST_BRIDGE_OC_BIT = 0;
  localparam int unsigned ST_HS_OC_BIT = 1;
  localparam int unsigned ST_OVV_BIT = 2;
  localparam int unsigned ST_OT_BIT = 3;
  localparam int unsigned ST_STANDBY_BIT = 4;
  localparam int unsigned ST_THERM_OFF_BIT = 5;
  localparam int unsigned ST_CMD_LSB = 8;
  localparam int unsigned ST_KILL_LSB = 16;
  localparam int unsigned CTRL_FORCE_TRI_BIT = 0;
  localparam logic CTRL_FORCE_TRI_RESET = 1'b0;

  // ---------------------------------------------------------------------
  // command and diagnostic encodings
  // ---------------------------------------------------------------------
  localparam logic [3:0] NIB_MOTOR_FIRST = 4'h1;
  localparam logic [3:0] NIB_MOTOR_LAST = 4'h6;
  localparam logic [3:0] NIB_BRAKE = 4'h9;
  localparam logic [3:0] NIB_HS_ON = 4'hA;
  localparam logic [3:0] NIB_STANDBY = 4'h0;
  localparam logic [2:0] TEST_SRC = 3'h2;
  localparam logic [2:0] TEST_SNK = 3'h1;
  localparam logic [2:0] TEST_ALL = 3'h6;
  localparam logic [1:0] FAIL_NONE = 2'h0;
  localparam logic [1:0] FAIL_BRIDGE_OVERCURRENT_FLAG = 2'h1;
  localparam logic [1:0] FAIL_HIGHSIDE_OVERCURRENT_FLAG = 2'h2;
  localparam logic [1:0] FAIL_OVV = 2'h3;

  typedef enum logic [2:0] {
    DRV_TRI = 3'h0, DRV_HIGH = 3'h1, DRV_LOW = 3'h2,
    DRV_SRC = 3'h3, DRV_SNK = 3'h4
  } drive_t;

  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00, ST_IDLE = 2'b01, ST_SELECTED = 2'b11
  } bus_state_t;

  typedef struct packed {
    drive_t hs;
    drive_t o4;
    drive_t o3;
    drive_t o2;
    drive_t o1;
  } out_drive_t;

  typedef struct packed {
    logic mode;
    logic [3:0] nibble;
  } command_t;

  typedef struct packed {
    logic sel;
    logic rnw;
    logic mode;
    logic [3:0] nib;
    logic [4:0] limit;
    logic supply_overvoltage_flag;
    logic tsd;
    logic trel;
    logic twarn;
    logic gndLoss;
    logic logicUv;
    logic [4:0] level;
  } pin_in_t;

  localparam int unsigned PIN_W = $bits(pin_in_t);
  localparam out_drive_t ALL_TRI = {DRV_TRI, DRV_TRI, DRV_TRI, DRV_TRI, DRV_TRI};
  localparam command_t CMD_RESET = 5'h00;

  // maps a latched command onto the five output stages
  function automatic out_drive_t decode_command(command_t c);
    out_drive_t d;
    logic [3:0] k;
    drive_t a;
    d = ALL_TRI;
    k = c.nibble - NIB_MOTOR_FIRST;
    a = k[0] ? DRV_LOW : DRV_HIGH;
    if (!c.mode) begin
      if (c.nibble >= NIB_MOTOR_FIRST && c.nibble <= NIB_MOTOR_LAST) begin
        d.o4 = k[0] ? DRV_HIGH : DRV_LOW;
        case (k[2:1])
          2'h0: d.o1 = a;
          2'h1: d.o2 = a;
          default: d.o3 = a;
        endcase
      end else if (c.nibble == NIB_BRAKE) begin
        d = {DRV_TRI, DRV_LOW, DRV_LOW, DRV_LOW, DRV_LOW};
      end else if (c.nibble == NIB_HS_ON) begin
        d.hs = DRV_HIGH;
      end
    end else begin
      case (c.nibble[2:0])
        TEST_SRC: d.o4 = DRV_SRC;
        TEST_SNK: d.o4 = DRV_SNK;
        TEST_ALL: d = {DRV_SRC, DRV_SRC, DRV_SNK, DRV_SNK, DRV_SNK};
        default: d = ALL_TRI;
      endcase
    end
    return d;
  endfunction : decode_command

endpackage : power_stage_pkg

`default_nettype wire

// file: rtl/pin_sync.sv
/*
  Three-stage input filter for signals from outside the clock domain.
  A new level is accepted once the second and third stages agree.
  Assumes a free-running clk and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_d;
  logic [W-1:0] out_q;

  // per bit, take the level only where the last two stages agree
  assign out_d = (s2_q & s3_q) | (out_q & (s2_q ^ s3_q));
  assign dout = out_q;

  // synchroniser chain
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else if (ce) begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

endmodule : pin_sync

`default_nettype wire

// file: rtl/power_stage_diag_and_protect.sv
/*
  Control and protection logic of a bus-commanded power output stage:
  parallel nibble bus, command latch, standby and timeout clear,
  overcurrent timers and flags, thermal and overvoltage shutdown,
  diagnostic read-back and an APB status/control window.
  Assumes analog indications arrive as asynchronous levels and that the
  pad logic resolves the data pins from commandNibbleOe.
*/
// Decided for this implementation: the register offsets and the APB slave port.
// Behaviour
// - read mode shows levels and fault flags
// - overcurrent flags stay until next write
// - bridge overcurrent sets first flag
// - high-side overcurrent sets second flag
// - temperature warning flag shown before shutdown
// - first tests: fourth output sources or sinks
// - third test: sinks, source, high-side source
// - rising select, inputs low: standby, clear
// - leaving standby starts with cleared command
// - select low too long: clear, tristate
// - select input pulled low internally
// - after timeout stay standby until falling select
// - thermal shutdown holds outputs off with hysteresis
// - overvoltage forces all outputs tristate
// - overvoltage end restores commanded outputs
// - logic undervoltage resets logic, tristates outputs
// - ground loss switches high-side off
// - write mode takes nibble, rising select latches
// - read mode drives status, outputs unchanged
// - sustained current limit switches output off
// - high-side only on when bridges tristate
`timescale 1ns/1ps
`default_nettype none

module power_stage_diag_and_protect
  import power_stage_pkg::*;
#(
  parameter int unsigned CLEAR_TIMEOUT_CYCLES = CLEAR_TIMEOUT_CYC,
  parameter int unsigned LIMIT_OFF_CYCLES = LIMIT_OFF_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic busSelectLow,
  input wire logic readNotWriteSel,
  input wire logic modeSel,
  input wire logic [3:0] commandNibbleIn,
  output logic [3:0] commandNibbleOut,
  output logic commandNibbleOe,
  output logic selPullDownEn,
  input wire logic [4:0] currentLimit,
  input wire logic supplyOvervoltage,
  input wire logic thermalShutdown,
  input wire logic thermalRelease,
  input wire logic thermalWarning,
  input wire logic groundLoss,
  input wire logic logicUndervoltage,
  input wire logic [4:0] outputLevelHigh,
  output out_drive_t outDrive
);

  // ---------------------------------------------------------------------
  // input filtering
  // ---------------------------------------------------------------------
  wire logic [PIN_W-1:0] pinRaw;
  wire logic [PIN_W-1:0] pinSync;
  pin_in_t pinF;

  // bundle all outside levels in struct order
  assign pinRaw = {busSelectLow, readNotWriteSel, modeSel, commandNibbleIn,
                   currentLimit, supplyOvervoltage, thermalShutdown,
                   thermalRelease, thermalWarning, groundLoss,
                   logicUndervoltage, outputLevelHigh};
  assign pinF = pinSync;

  pin_sync #(.W(PIN_W)) u_pin_sync (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .din(pinRaw),
    .dout(pinSync)
  );

  // undervoltage acts as a reset of the bus-facing logic
  wire logic logicRstn;
  assign logicRstn = resetn & ~pinF.logicUv;

  // ---------------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------------
  bus_state_t state_q;
  bus_state_t state_d;
  logic selPrev_q;
  logic [TIMER_W-1:0] tmoCnt_q;
  logic wrote_q;
  command_t cmd_q;
  wire logic selected;
  wire logic selFall;
  wire logic selRise;
  wire logic awake;
  wire logic writeAcc;
  wire logic readAcc;
  wire logic standbyReq;
  wire logic timeoutHit;
  wire logic wrDone;
  wire logic clearLatch;

  assign selPullDownEn = 1'b1;
  assign selected = ~pinF.sel;
  assign selFall = selPrev_q & ~pinF.sel;
  assign selRise = ~selPrev_q & pinF.sel;
  assign awake = state_q != ST_STANDBY;
  assign writeAcc = (state_q == ST_SELECTED) & selected & ~pinF.rnw;
  assign readAcc = (state_q == ST_SELECTED) & selected & pinF.rnw;
  assign standbyReq = selRise & ~pinF.rnw & ~pinF.mode
                      & (pinF.nib == NIB_STANDBY);
  assign timeoutHit = selected & (state_q == ST_SELECTED)
                      & (tmoCnt_q == TIMER_W'(CLEAR_TIMEOUT_CYCLES - 1));
  assign wrDone = (state_q == ST_SELECTED) & selRise & wrote_q;
  assign clearLatch = timeoutHit | (state_q == ST_SELECTED & standbyReq)
                      | (state_q == ST_STANDBY & selFall);

  // state transitions of the select handshake
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_STANDBY: if (selFall) state_d = ST_SELECTED;
      ST_IDLE: if (selFall) state_d = ST_SELECTED;
      ST_SELECTED: begin
        if (timeoutHit) begin
          state_d = ST_STANDBY;
        end else if (selRise) begin
          state_d = standbyReq ? ST_STANDBY : ST_IDLE;
        end
      end
      default: state_d = ST_STANDBY;
    endcase
  end

  // select history, state and clear timer
  always_ff @(posedge clk) begin
    if (!logicRstn) begin
      state_q <= ST_STANDBY;
      selPrev_q <= 1'b0;
      tmoCnt_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
      selPrev_q <= pinF.sel;
      if (selFall || !selected) begin
        tmoCnt_q <= '0;
      end else if (tmoCnt_q != TIMER_W'(CLEAR_TIMEOUT_CYCLES)) begin
        tmoCnt_q <= tmoCnt_q + 1'b1;
      end
    end
  end

  // command latch follows the nibble during write, holds after select
  always_ff @(posedge clk) begin
    if (!logicRstn) begin
      cmd_q <= CMD_RESET;
      wrote_q <= 1'b0;
    end else if (ce) begin
      if (clearLatch) begin
        cmd_q <= CMD_RESET;
      end else if (writeAcc) begin
        cmd_q <= {pinF.mode, pinF.nib};
      end
      if (selFall || clearLatch) begin
        wrote_q <= 1'b0;
      end else if (writeAcc) begin
        wrote_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------
  // overcurrent timers and flags
  // ---------------------------------------------------------------------
  out_drive_t cmdDrive;
  wire logic [4:0] driven;
  wire logic [4:0] trip;
  logic [4:0] kill_q;
  logic bridgeOc_q;
  logic hsOc_q;

  assign cmdDrive = decode_command(cmd_q);
  assign driven = {cmdDrive.hs != DRV_TRI, cmdDrive.o4 != DRV_TRI,
                   cmdDrive.o3 != DRV_TRI, cmdDrive.o2 != DRV_TRI,
                   cmdDrive.o1 != DRV_TRI};

  // one limit timer per output stage
  for (genvar i = 0; i < NUM_OUT; i++) begin : g_limit
    logic [TIMER_W-1:0] cnt_q;
    wire logic counting;
    assign counting = pinF.limit[i] & driven[i] & ~kill_q[i];
    assign trip[i] = counting
                     & (cnt_q == TIMER_W'(LIMIT_OFF_CYCLES - 1));
    always_ff @(posedge clk) begin
      if (!logicRstn) begin
        cnt_q <= '0;
      end else if (ce) begin
        cnt_q <= counting ? cnt_q + 1'b1 : '0;
      end
    end
  end

  // latched switch-off and flags; a trip wins over a write's clear
  always_ff @(posedge clk) begin
    if (!logicRstn) begin
      kill_q <= '0;
      bridgeOc_q <= 1'b0;
      hsOc_q <= 1'b0;
    end else if (ce) begin
      kill_q <= trip | (kill_q & ~{5{wrDone | clearLatch}});
      if (|trip[3:0]) begin
        bridgeOc_q <= 1'b1;
      end else if (wrDone || clearLatch) begin
        bridgeOc_q <= 1'b0;
      end
      if (trip[4]) begin
        hsOc_q <= 1'b1;
      end else if (wrDone || clearLatch) begin
        hsOc_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------
  // protection and output stage drive
  // ---------------------------------------------------------------------
  logic thermOff_q;
  logic forceTri_q;
  out_drive_t outDrive_q;
  out_drive_t outDrive_d;
  wire logic blank;

  // thermal latch releases only below the hysteresis point
  always_ff @(posedge clk) begin
    if (!logicRstn) begin
      thermOff_q <= 1'b0;
    end else if (ce) begin
      if (pinF.tsd) begin
        thermOff_q <= 1'b1;
      end else if (pinF.trel) begin
        thermOff_q <= 1'b0;
      end
    end
  end

  // command is kept through overvoltage, so its end restores the outputs
  assign blank = ~awake | pinF.supply_overvoltage_flag | thermOff_q | pinF.tsd
                 | forceTri_q;

  // final drive: blanking, per-output switch-off, ground loss
  always_comb begin
    outDrive_d = cmdDrive;
    if (kill_q[0]) outDrive_d.o1 = DRV_TRI;
    if (kill_q[1]) outDrive_d.o2 = DRV_TRI;
    if (kill_q[2]) outDrive_d.o3 = DRV_TRI;
    if (kill_q[3]) outDrive_d.o4 = DRV_TRI;
    if (kill_q[4] || pinF.gndLoss) outDrive_d.hs = DRV_TRI;
    if (blank) outDrive_d = ALL_TRI;
  end

  always_ff @(posedge clk) begin
    if (!logicRstn) begin
      outDrive_q <= ALL_TRI;
    end else if (ce) begin
      outDrive_q <= outDrive_d;
    end
  end

  assign outDrive = outDrive_q;

  // ---------------------------------------------------------------------
  // diagnostic read-back on the data lines
  // ---------------------------------------------------------------------
  logic [3:0] dout_q;
  logic oe_q;
  wire logic [1:0] failCode;
  wire logic [3:0] diagWord;

  assign failCode = pinF.supply_overvoltage_flag ? FAIL_OVV :
                    bridgeOc_q ? FAIL_BRIDGE_OVERCURRENT_FLAG :
                    hsOc_q ? FAIL_HIGHSIDE_OVERCURRENT_FLAG : FAIL_NONE;
  assign diagWord = pinF.mode ? {pinF.level[4], pinF.twarn, failCode}
                              : pinF.level[3:0];

  always_ff @(posedge clk) begin
    if (!logicRstn) begin
      dout_q <= 4'h0;
      oe_q <= 1'b0;
    end else if (ce) begin
      dout_q <= diagWord;
      oe_q <= readAcc;
    end
  end

  assign commandNibbleOut = dout_q;
  assign commandNibbleOe = oe_q;

  // ---------------------------------------------------------------------
  // APB slave, zero wait states, read data captured in setup
  // ---------------------------------------------------------------------
  logic [31:0] prdata_q;
  logic pslverr_q;
  wire logic setup;
  wire logic wrCtrl;
  wire logic mapped;
  wire logic [31:0] statusWord;
  wire logic [31:0] rdMux;

  assign setup = psel & ~penable;
  assign mapped = paddr == STATUS_OFF | paddr == CTRL_OFF
                  | paddr == DRIVE_OFF;
  assign wrCtrl = psel & penable & pwrite & pstrb[0] & (paddr == CTRL_OFF);
  assign statusWord = (32'(bridgeOc_q) << ST_BRIDGE_OC_BIT)
                      | (32'(hsOc_q) << ST_HS_OC_BIT)
                      | (32'(pinF.supply_overvoltage_flag) << ST_OVV_BIT)
                      | (32'(pinF.twarn) << ST_OT_BIT)
                      | (32'(state_q == ST_STANDBY) << ST_STANDBY_BIT)
                      | (32'(thermOff_q) << ST_THERM_OFF_BIT)
                      | (32'(cmd_q) << ST_CMD_LSB)
                      | (32'(kill_q) << ST_KILL_LSB);
  assign rdMux = paddr == STATUS_OFF ? statusWord :
                 paddr == CTRL_OFF ? 32'(forceTri_q) << CTRL_FORCE_TRI_BIT :
                 paddr == DRIVE_OFF ? 32'(outDrive_q) : 32'h0000_0000;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      forceTri_q <= CTRL_FORCE_TRI_RESET;
    end else if (ce) begin
      if (setup) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rdMux;
        pslverr_q <= ~mapped;
      end
      if (wrCtrl) begin
        forceTri_q <= pwdata[CTRL_FORCE_TRI_BIT];
      end
    end
  end

  // ---------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!logicRstn || !ce);

  property p_flag_clear;
    wrDone && !(|trip) ##1 ce |-> !bridgeOc_q && !hsOc_q;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("overcurrent flag survived a write");

  property p_bridge_set;
    (|trip[3:0]) |=> bridgeOc_q && kill_q[3:0] != 4'h0;
  endproperty
  a_bridge_set: assert property (p_bridge_set)
    else $error("bridge overcurrent flag not set");

  property p_hs_set;
    trip[4] |=> hsOc_q ##1 outDrive.hs == DRV_TRI;
  endproperty
  a_hs_set: assert property (p_hs_set)
    else $error("high-side overcurrent not handled");

  property p_standby_entry;
    state_q == ST_SELECTED && standbyReq && !timeoutHit |=>
      state_q == ST_STANDBY && cmd_q == CMD_RESET ##1 outDrive == ALL_TRI;
  endproperty
  a_standby_entry: assert property (p_standby_entry)
    else $error("standby entry did not clear");

  property p_timeout;
    timeoutHit |=> state_q == ST_STANDBY && cmd_q == CMD_RESET;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout clear missing");

  property p_stay_standby;
    state_q == ST_STANDBY && !selFall |=> state_q == ST_STANDBY;
  endproperty
  a_stay_standby: assert property (p_stay_standby)
    else $error("standby left without falling select");

  property p_ovv_tri;
    pinF.supply_overvoltage_flag |=> outDrive == ALL_TRI;
  endproperty
  a_ovv_tri: assert property (p_ovv_tri)
    else $error("output driven during overvoltage");

  property p_therm_hold;
    thermOff_q && !pinF.trel |=> thermOff_q && outDrive == ALL_TRI;
  endproperty
  a_therm_hold: assert property (p_therm_hold)
    else $error("thermal latch released early");

  property p_gnd_loss;
    pinF.gndLoss |=> outDrive.hs == DRV_TRI;
  endproperty
  a_gnd_loss: assert property (p_gnd_loss)
    else $error("high-side on after ground loss");

  property p_read_oe;
    readAcc |=> commandNibbleOe && commandNibbleOut == $past(diagWord);
  endproperty
  a_read_oe: assert property (p_read_oe)
    else $error("diagnostic word not driven");

  property p_quiet_bus;
    !readAcc |=> !commandNibbleOe;
  endproperty
  a_quiet_bus: assert property (p_quiet_bus)
    else $error("data lines driven outside read mode");

  property p_hs_exclusive;
    outDrive.hs == DRV_HIGH |-> outDrive.o1 == DRV_TRI
      && outDrive.o2 == DRV_TRI && outDrive.o3 == DRV_TRI
      && outDrive.o4 == DRV_TRI;
  endproperty
  a_hs_exclusive: assert property (p_hs_exclusive)
    else $error("high-side on with a bridge driven");

endmodule : power_stage_diag_and_protect

`default_nettype wire

// file: test/mcu_model.sv
/*
  Bus master model of the nibble bus: one frame per select low pulse.
  Assumes the device drives the data pins only while its enable is high.
*/
`timescale 1ns/1ps
`default_nettype none

module mcu_model (
  input wire logic clk,
  input wire logic devOe,
  input wire logic [3:0] devData,
  output logic selLow,
  output logic rnw,
  output logic mode,
  output logic [3:0] pins
);
  logic [3:0] nibQ;
  // a released data line shows the inverse of its last value
  assign pins = devOe ? devData : (rnw ? ~nibQ : nibQ);
  initial begin
    selLow = 1'b1;
    rnw = 1'b0;
    mode = 1'b0;
    nibQ = 4'h0;
  end
  // setup, select low for len cycles, sample pins, select high
  task automatic frame(input logic r, input logic m, input logic [3:0] n,
      input int len, output logic [3:0] seen);
    @(posedge clk);
    rnw <= r;
    mode <= m;
    nibQ <= n;
    repeat (6) @(posedge clk);
    selLow <= 1'b0;
    repeat (len) @(negedge clk);
    seen = pins;
    @(posedge clk);
    selLow <= 1'b1;
    repeat (12) @(posedge clk);
  endtask : frame
endmodule : mcu_model

`default_nettype wire

// file: test/tb.sv
/*
  Self-checking bench of the power stage control block.
  Assumes the bus master model runs the nibble bus; APB is driven here.
*/
`timescale 1ns/1ps
`default_nettype none

module tb
  import power_stage_pkg::*;
;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, e;
  logic supply_overvoltage_flag, tsd, trel, twarn, gnd, luv, oe, selLow, rnw, mode, pd;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] pins, dOut, s;
  logic [4:0] limit, lvl;
  out_drive_t drv;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  localparam out_drive_t MOT = '{DRV_TRI,DRV_LOW,DRV_TRI,DRV_TRI,DRV_HIGH};
  localparam out_drive_t K1 = '{DRV_TRI,DRV_LOW,DRV_TRI,DRV_TRI,DRV_TRI};
  localparam out_drive_t HS = '{DRV_HIGH,DRV_TRI,DRV_TRI,DRV_TRI,DRV_TRI};

  power_stage_diag_and_protect #(.CLEAR_TIMEOUT_CYCLES(40),
    .LIMIT_OFF_CYCLES(30)) dut (.clk, .resetn, .ce(1'b1), .paddr, .psel,
    .penable, .pwrite, .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr,
    .busSelectLow(selLow), .readNotWriteSel(rnw), .modeSel(mode),
    .commandNibbleIn(pins), .commandNibbleOut(dOut), .commandNibbleOe(oe),
    .selPullDownEn(pd), .currentLimit(limit), .supplyOvervoltage(supply_overvoltage_flag),
    .thermalShutdown(tsd), .thermalRelease(trel), .thermalWarning(twarn),
    .groundLoss(gnd), .logicUndervoltage(luv), .outputLevelHigh(lvl),
    .outDrive(drv));
  mcu_model mcu (.clk, .devOe(oe), .devData(dOut), .selLow, .rnw, .mode,
    .pins);

  // ----------------------------------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic chkD(input out_drive_t exp);
    chk(32'(drv), 32'(exp));
  endtask : chkD
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask : hold
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // scenarios
  task automatic t_reset();
    chkD(ALL_TRI);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk(r[ST_STANDBY_BIT], 1'b1);
    apb(1'b0, CTRL_OFF, 32'h0);
    chk(r, 32'(CTRL_FORCE_TRI_RESET));
    apb(1'b0, 12'h00C, 32'h0);
    chk(r, 32'h0000_0000);
    chk(32'(e), 32'h0000_0001);
    chk(32'(pd), 32'h0000_0001);
  endtask : t_reset
  task automatic t_motor();
    mcu.frame(1'b0, 1'b0, 4'h1, 12, s);
    chkD(MOT);
    mcu.frame(1'b1, 1'b0, 4'h0, 12, s);
    chk(s, lvl[3:0]);
    chkD(MOT);
    chk(oe, 1'b0);
  endtask : t_motor
  task automatic t_oc();
    limit <= 5'h01;
    hold(45);
    limit <= 5'h00;
    chkD(K1);
    repeat (2) begin
      mcu.frame(1'b1, 1'b1, 4'h0, 12, s);
      chk(s, {lvl[4], 1'b0, FAIL_BRIDGE_OVERCURRENT_FLAG});
    end
    mcu.frame(1'b0, 1'b0, NIB_HS_ON, 12, s);
    chkD(HS);
    limit <= 5'h10;
    hold(45);
    limit <= 5'h00;
    mcu.frame(1'b1, 1'b1, 4'h0, 12, s);
    chk(s, {lvl[4], 1'b0, FAIL_HIGHSIDE_OVERCURRENT_FLAG});
  endtask : t_oc
  task automatic t_tests();
    logic [2:0] code [3] = '{TEST_SRC, TEST_SNK, TEST_ALL};
    out_drive_t want [3] = '{'{DRV_TRI,DRV_SRC,DRV_TRI,DRV_TRI,DRV_TRI},
      '{DRV_TRI,DRV_SNK,DRV_TRI,DRV_TRI,DRV_TRI},
      '{DRV_SRC,DRV_SRC,DRV_SNK,DRV_SNK,DRV_SNK}};
    for (int i = 0; i < 3; i++) begin
      mcu.frame(1'b0, 1'b1, {1'b0, code[i]}, 12, s);
      chkD(want[i]);
    end
    mcu.frame(1'b0, 1'b0, NIB_BRAKE, 12, s);
    chkD('{DRV_TRI,DRV_LOW,DRV_LOW,DRV_LOW,DRV_LOW});
    mcu.frame(1'b0, 1'b0, 4'h4, 12, s);
    chkD('{DRV_TRI,DRV_HIGH,DRV_TRI,DRV_LOW,DRV_TRI});
  endtask : t_tests
  task automatic t_prot();
    mcu.frame(1'b0, 1'b0, 4'h1, 12, s);
    supply_overvoltage_flag <= 1'b1;
    hold(8);
    chkD(ALL_TRI);
    mcu.frame(1'b1, 1'b1, 4'h0, 12, s);
    chk(s, {lvl[4], 1'b0, FAIL_OVV});
    supply_overvoltage_flag <= 1'b0;
    hold(8);
    chkD(MOT);
    twarn <= 1'b1;
    mcu.frame(1'b1, 1'b1, 4'h0, 12, s);
    chk(s, {lvl[4], 1'b1, FAIL_NONE});
    twarn <= 1'b0;
    tsd <= 1'b1;
    hold(8);
    tsd <= 1'b0;
    hold(8);
    chkD(ALL_TRI);
    trel <= 1'b1;
    hold(8);
    chkD(MOT);
    trel <= 1'b0;
    mcu.frame(1'b0, 1'b0, NIB_HS_ON, 12, s);
    gnd <= 1'b1;
    hold(8);
    chkD(ALL_TRI);
    gnd <= 1'b0;
    apb(1'b1, CTRL_OFF, 32'h1);
    hold(8);
    chkD(ALL_TRI);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk(r[12:8], {1'b0, NIB_HS_ON});
    apb(1'b1, CTRL_OFF, 32'h0);
    hold(8);
    chkD(HS);
  endtask : t_prot
  task automatic t_standby();
    mcu.frame(1'b0, 1'b0, 4'h0, 12, s);
    chkD(ALL_TRI);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk(r[ST_STANDBY_BIT], 1'b1);
    mcu.frame(1'b0, 1'b0, 4'h1, 60, s);
    chkD(ALL_TRI);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk(r[ST_STANDBY_BIT], 1'b1);
    mcu.frame(1'b1, 1'b0, 4'h0, 12, s);
    chkD(ALL_TRI);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk(r[ST_STANDBY_BIT], 1'b0);
    mcu.frame(1'b0, 1'b0, 4'h1, 12, s);
    chkD(MOT);
    luv <= 1'b1;
    hold(8);
    luv <= 1'b0;
    hold(8);
    chkD(ALL_TRI);
    mcu.frame(1'b0, 1'b0, 4'h1, 12, s);
    chkD(MOT);
  endtask : t_standby

  // main sequence
  initial begin
    {resetn, psel, penable, pwrite, supply_overvoltage_flag, tsd, trel, twarn, gnd, luv} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    limit = 5'h00;
    lvl = 5'h19;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_motor();
    t_oc();
    t_tests();
    t_prot();
    t_standby();
    report_and_stop();
  end
endmodule : tb

`default_nettype wire
